// *** clkcfg_pkg.sv ***
// Constants, register map and mode decoding for the clock divider configuration block.
// Assumes a single 125 MHz bus clock that also stands in for the oscillator input.
package clkcfg_pkg;

    typedef logic [16:0] khz_t;

    // Register byte offsets
    localparam logic [7:0] CFG_OFS  = 8'h00;
    localparam logic [7:0] TRIM_OFS = 8'h04;
    localparam logic [7:0] STEP_OFS = 8'h08;
    localparam logic [7:0] STAT_OFS = 8'h0C;
    localparam logic [7:0] CORE_OFS = 8'h10;
    localparam logic [7:0] USB_OFS  = 8'h14;

    // Configuration register fields
    localparam int PRE_LSB    = 0;
    localparam int POST_LSB   = 4;
    localparam int MODE_LSB   = 8;
    localparam int USB_CLOCK_DIVIDER_SEL_BIT = 12;
    localparam int LSREQ_BIT  = 13;

    // Trim step register fields (write-only strobes)
    localparam int STEP_INC_BIT = 0;
    localparam int STEP_DEC_BIT = 1;

    // Status register fields
    localparam int ST_VALID_BIT = 0;
    localparam int ST_LOOP_BIT  = 1;
    localparam int ST_FS_BIT    = 2;
    localparam int ST_LS_BIT    = 3;
    localparam int ST_PRE_BIT   = 4;

    // Reset values
    localparam logic [2:0] PRE_RST  = 3'h0;
    localparam logic [1:0] POST_RST = 2'h0;
    localparam logic [3:0] MODE_RST = 4'h0;
    localparam logic [4:0] TRIM_RST = 5'h00;

    // Signed trim limits
    localparam logic [4:0] TRIM_MAX = 5'h0F;
    localparam logic [4:0] TRIM_MIN = 5'h10;

    // Largest legal prescaler code (divide by 5)
    localparam logic [2:0] PRE_MAX = 3'h4;

    // Clock mode codes
    localparam logic [3:0] HIGH_SPEED_CRYSTAL      = 4'h0;
    localparam logic [3:0] LOW_SPEED_CRYSTAL       = 4'h1;
    localparam logic [3:0] EXTERNAL_CLOCK_OUT      = 4'h2;
    localparam logic [3:0] EXTERNAL_CLOCK_WITH_IO  = 4'h3;
    localparam logic [3:0] HIGH_SPEED_CRYSTAL_LOOP = 4'h4;
    localparam logic [3:0] LOW_SPEED_CRYSTAL_LOOP  = 4'h5;
    localparam logic [3:0] EXTERNAL_CLOCK_LOOP     = 4'h6;
    localparam logic [3:0] EXTERNAL_CLOCK_LOOP_IO  = 4'h7;

    // Frequencies in kHz
    localparam khz_t REF_KHZ    = 17'h00FA0;
    localparam khz_t LOOP_KHZ   = 17'h17700;
    localparam khz_t USB_FS_KHZ = 17'h0BB80;
    localparam khz_t USB_LS_KHZ = 17'h01770;
    localparam khz_t CORE_24    = 17'h05DC0;
    localparam khz_t CORE_16    = 17'h03E80;
    localparam khz_t CORE_32    = 17'h07D00;
    localparam khz_t CORE_48    = 17'h0BB80;

    function automatic logic mode_known(input logic [3:0] m);
        return m <= EXTERNAL_CLOCK_LOOP_IO;
    endfunction

    function automatic logic mode_loop(input logic [3:0] m);
        return mode_known(m) && m[2];
    endfunction

    function automatic logic mode_low_xt(input logic [3:0] m);
        return (m == LOW_SPEED_CRYSTAL) || (m == LOW_SPEED_CRYSTAL_LOOP);
    endfunction

    // Loop postscaler code to divide-minus-one: 2, 3, 4, 6
    function automatic logic [2:0] loop_div_m1(input logic [1:0] c);
        unique case (c)
            2'h0: return 3'h1;
            2'h1: return 3'h2;
            2'h2: return 3'h3;
            2'h3: return 3'h5;
        endcase
    endfunction

endpackage

// *** clk_div.sv ***
// Integer tick divider: one output pulse for every div_m1+1 input ticks.
// Assumes in_tick and div_m1 are synchronous to hclk.
`timescale 1ns/10ps
module clk_div (
    input  wire logic       hclk,
    input  wire logic       hresetn,
    input  wire logic       in_tick,
    input  wire logic [2:0] div_m1,
    output logic            out_tick
);
    logic [2:0] cnt_q;
    logic [2:0] cnt_d;
    logic       tick_d;

    always_comb begin
        cnt_d  = cnt_q;
        tick_d = 1'b0;
        if (in_tick) begin
            // A shrinking divide value must not leave the count stranded above it
            if (cnt_q >= div_m1) begin
                cnt_d  = 3'h0;
                tick_d = 1'b1;
            end else begin
                cnt_d = cnt_q + 3'h1;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cnt_q    <= 3'h0;
            out_tick <= 1'b0;
        end else begin
            cnt_q    <= cnt_d;
            out_tick <= tick_d;
        end
    end

    a_div_wrap: assert property (@(posedge hclk) disable iff (!hresetn)
        (in_tick && cnt_q == div_m1) |=> out_tick)
        else $error("divider missed its output tick");

    a_div_hold: assert property (@(posedge hclk) disable iff (!hresetn)
        (in_tick && cnt_q < div_m1) |=> !out_tick ##0 (cnt_q == $past(cnt_q) + 3'h1))
        else $error("divider ticked early or skipped a count");

endmodule

// *** trim_reg.sv ***
// Signed 5-bit fast oscillator trim with direct write and saturating steps.
// Assumes the strobes are one-cycle pulses from the bus slave.
`timescale 1ns/10ps
module trim_reg
    import clkcfg_pkg::*;
(
    input  wire logic       hclk,
    input  wire logic       hresetn,
    input  wire logic       wr_en,
    input  wire logic [4:0] wr_val,
    input  wire logic       inc,
    input  wire logic       dec,
    output logic [4:0]      trim_q
);
    logic [4:0] trim_d;

    always_comb begin
        trim_d = trim_q;
        if (wr_en) begin
            trim_d = wr_val;
        end else if (inc && !dec && trim_q != TRIM_MAX) begin
            trim_d = trim_q + 5'h01;
        end else if (dec && !inc && trim_q != TRIM_MIN) begin
            trim_d = trim_q - 5'h01;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            trim_q <= TRIM_RST;
        end else begin
            trim_q <= trim_d;
        end
    end

    a_trim_top: assert property (@(posedge hclk) disable iff (!hresetn)
        (!wr_en && inc && !dec && trim_q == TRIM_MAX) |=> trim_q == TRIM_MAX)
        else $error("trim wrapped past maximum");

    a_trim_bottom: assert property (@(posedge hclk) disable iff (!hresetn)
        (!wr_en && dec && !inc && trim_q == TRIM_MIN) |=> trim_q == TRIM_MIN)
        else $error("trim wrapped past minimum");

endmodule

// *** usb_clock_divider_config.sv ***
// Clock divider configuration: AHB-Lite registers, prescaler, postscaler, trim.
// Assumes hclk stands in for the oscillator input and loop_out_tick marks loop output edges.
`timescale 1ns/10ps

// Function
// - Trim writes alter only the fast internal oscillator, never the slow RC one.
// - Prescaler divides input by 1 to 5 for codes 000 through 100.
// - Without the loop, postscaler divides the oscillator by 1, 2, 3 or 4.
// - With the loop, postscaler gives 48, 32, 24 or 16 MHz core clocks.
// - Low-speed crystal modes need a 4 MHz input and prescaler code 000.
// - Low-speed USB only with 24 MHz core and 6 MHz USB from the loop.
// - All other core clocks serve full-speed USB only, at 48 MHz.
// - Divider combinations hold only while the USB divider selection is clear.
// - Trim is signed: 00000 centre, 01111 maximum, 10000 minimum.
// - The loop makes a fixed 96 MHz from a fixed 4 MHz reference.
module usb_clock_divider_config (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    input  wire logic        loop_out_tick,
    output logic             loop_enable,
    output logic             loop_ref_tick,
    output logic             core_tick,
    output logic             core_from_loop,
    output logic             usb_low_speed,
    output logic [4:0]       fast_osc_trim,
    output clkcfg_pkg::khz_t core_khz,
    output clkcfg_pkg::khz_t usb_khz,
    output clkcfg_pkg::khz_t loop_khz
);
    import clkcfg_pkg::*;

    typedef enum logic [1:0] {BUS_IDLE, BUS_WRITE, BUS_READ, BUS_RDONE} bus_state_t;

    bus_state_t  bus_q;
    bus_state_t  bus_d;
    logic [7:0]  addr_q;
    logic [7:0]  addr_d;
    logic        hit_q;
    logic        hit_d;
    logic [31:0] rdata_d;
    logic        accept;
    logic        wr_cfg;
    logic        wr_trim;
    logic        wr_step;

    logic [2:0]  pre_q;
    logic [2:0]  pre_d;
    logic [1:0]  post_q;
    logic [1:0]  post_d;
    logic [3:0]  mode_q;
    logic [3:0]  mode_d;
    logic        usb_clock_divider_sel_q;
    logic        usb_clock_divider_sel_d;
    logic        lsreq_q;
    logic        lsreq_d;

    logic        pre_ok;
    logic        valid_d;
    logic        loop_d;
    logic        ls_ok_d;
    khz_t        in_khz;
    khz_t        core_khz_d;
    khz_t        usb_khz_d;
    logic        valid_q;
    logic        ls_ok_q;
    logic        usb_ls_d;

    logic        post_in;
    logic [2:0]  post_m1;

    // Bus slave: zero-wait writes, one wait state on reads so read data comes from a flop
    assign accept    = hsel && htrans[1] && hready;
    assign hreadyout = (bus_q != BUS_READ);
    assign hresp     = 1'b0;
    assign wr_cfg    = (bus_q == BUS_WRITE) && hit_q && (addr_q == CFG_OFS);
    assign wr_trim   = (bus_q == BUS_WRITE) && hit_q && (addr_q == TRIM_OFS);
    assign wr_step   = (bus_q == BUS_WRITE) && hit_q && (addr_q == STEP_OFS);

    always_comb begin
        bus_d  = bus_q;
        addr_d = addr_q;
        hit_d  = hit_q;
        unique case (bus_q)
            BUS_READ: begin
                bus_d = BUS_RDONE;
            end
            BUS_IDLE, BUS_WRITE, BUS_RDONE: begin
                bus_d = BUS_IDLE;
                if (accept) begin
                    bus_d  = hwrite ? BUS_WRITE : BUS_READ;
                    addr_d = {haddr[7:2], 2'b00};
                    // Anything beyond the low 256 bytes is unmapped
                    hit_d  = (haddr[31:8] == 24'h000000);
                end
            end
        endcase
    end

    always_comb begin
        rdata_d = hrdata;
        if (bus_q == BUS_READ) begin
            rdata_d = 32'h00000000;
            if (hit_q) begin
                unique case (addr_q)
                    CFG_OFS: begin
                        rdata_d[PRE_LSB +: 3]  = pre_q;
                        rdata_d[POST_LSB +: 2] = post_q;
                        rdata_d[MODE_LSB +: 4] = mode_q;
                        rdata_d[USB_CLOCK_DIVIDER_SEL_BIT]    = usb_clock_divider_sel_q;
                        rdata_d[LSREQ_BIT]     = lsreq_q;
                    end
                    TRIM_OFS: rdata_d[4:0] = fast_osc_trim;
                    STAT_OFS: begin
                        rdata_d[ST_VALID_BIT] = valid_q;
                        rdata_d[ST_LOOP_BIT]  = core_from_loop;
                        rdata_d[ST_FS_BIT]    = valid_q;
                        rdata_d[ST_LS_BIT]    = ls_ok_q;
                        rdata_d[ST_PRE_BIT]   = (pre_q <= PRE_MAX);
                    end
                    CORE_OFS: rdata_d[16:0] = core_khz;
                    USB_OFS:  rdata_d[16:0] = usb_khz;
                    default:  rdata_d = 32'h00000000;
                endcase
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            bus_q  <= BUS_IDLE;
            addr_q <= 8'h00;
            hit_q  <= 1'b0;
            hrdata <= 32'h00000000;
        end else begin
            bus_q  <= bus_d;
            addr_q <= addr_d;
            hit_q  <= hit_d;
            hrdata <= rdata_d;
        end
    end

    // Configuration selections
    always_comb begin
        pre_d    = pre_q;
        post_d   = post_q;
        mode_d   = mode_q;
        usb_clock_divider_sel_d = usb_clock_divider_sel_q;
        lsreq_d  = lsreq_q;
        if (wr_cfg) begin
            pre_d    = hwdata[PRE_LSB +: 3];
            post_d   = hwdata[POST_LSB +: 2];
            mode_d   = hwdata[MODE_LSB +: 4];
            usb_clock_divider_sel_d = hwdata[USB_CLOCK_DIVIDER_SEL_BIT];
            lsreq_d  = hwdata[LSREQ_BIT];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pre_q    <= PRE_RST;
            post_q   <= POST_RST;
            mode_q   <= MODE_RST;
            usb_clock_divider_sel_q <= 1'b0;
            lsreq_q  <= 1'b0;
        end else begin
            pre_q    <= pre_d;
            post_q   <= post_d;
            mode_q   <= mode_d;
            usb_clock_divider_sel_q <= usb_clock_divider_sel_d;
            lsreq_q  <= lsreq_d;
        end
    end

    // Derived clock plan; the input rate is inferred from the prescaler that brings it to 4 MHz
    always_comb begin
        pre_ok = (pre_q <= PRE_MAX);
        unique case (pre_q)
            3'h0:    in_khz = REF_KHZ;
            3'h1:    in_khz = 17'h01F40;
            3'h2:    in_khz = 17'h02EE0;
            3'h3:    in_khz = 17'h03E80;
            3'h4:    in_khz = 17'h04E20;
            default: in_khz = 17'h00000;
        endcase
        valid_d = pre_ok && mode_known(mode_q)
                  && (!mode_low_xt(mode_q) || pre_q == 3'h0)
                  && !usb_clock_divider_sel_q;
        loop_d = valid_d && mode_loop(mode_q);
        core_khz_d = 17'h00000;
        if (loop_d) begin
            unique case (post_q)
                2'h0: core_khz_d = CORE_48;
                2'h1: core_khz_d = CORE_32;
                2'h2: core_khz_d = CORE_24;
                2'h3: core_khz_d = CORE_16;
            endcase
        end else if (valid_d) begin
            unique case (post_q)
                2'h0: core_khz_d = in_khz;
                2'h1: core_khz_d = in_khz >> 1;
                2'h2: core_khz_d = khz_t'(in_khz / 17'h00003);
                2'h3: core_khz_d = in_khz >> 2;
            endcase
        end
        ls_ok_d   = loop_d && (post_q == 2'h2);
        usb_ls_d  = ls_ok_d && lsreq_q;
        usb_khz_d = !valid_d ? 17'h00000 : (usb_ls_d ? USB_LS_KHZ : USB_FS_KHZ);
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            valid_q        <= 1'b0;
            core_from_loop <= 1'b0;
            ls_ok_q        <= 1'b0;
            usb_low_speed  <= 1'b0;
            core_khz       <= 17'h00000;
            usb_khz        <= 17'h00000;
            loop_khz       <= 17'h00000;
        end else begin
            valid_q        <= valid_d;
            core_from_loop <= loop_d;
            ls_ok_q        <= ls_ok_d;
            usb_low_speed  <= usb_ls_d;
            core_khz       <= core_khz_d;
            usb_khz        <= usb_khz_d;
            loop_khz       <= valid_d ? LOOP_KHZ : 17'h00000;
        end
    end

    // The loop runs for USB in every valid plan, so its reference is always needed then
    assign loop_enable = valid_q;
    // Without the loop the postscaler counts oscillator cycles, with it loop edges
    assign post_in = core_from_loop ? loop_out_tick : valid_q;
    assign post_m1 = core_from_loop ? loop_div_m1(post_q) : {1'b0, post_q};

    clk_div u_prescale (
        .hclk     (hclk),
        .hresetn  (hresetn),
        .in_tick  (valid_q),
        .div_m1   (pre_q),
        .out_tick (loop_ref_tick)
    );

    clk_div u_postscale (
        .hclk     (hclk),
        .hresetn  (hresetn),
        .in_tick  (post_in),
        .div_m1   (post_m1),
        .out_tick (core_tick)
    );

    // Only the fast oscillator has a trim path; the slow RC clock is untouched
    trim_reg u_trim (
        .hclk    (hclk),
        .hresetn (hresetn),
        .wr_en   (wr_trim),
        .wr_val  (hwdata[4:0]),
        .inc     (wr_step && hwdata[STEP_INC_BIT]),
        .dec     (wr_step && hwdata[STEP_DEC_BIT]),
        .trim_q  (fast_osc_trim)
    );

    sequence s_trim_write;
        wr_trim ##1 1'b1;
    endsequence

    a_trim_fast_only: assert property (@(posedge hclk) disable iff (!hresetn)
        s_trim_write |-> fast_osc_trim == $past(hwdata[4:0]) && $stable(core_khz))
        else $error("trim write did not land or disturbed the clock plan");

    // Looks back from a tick so that a later CFG write cannot make the check fire
    a_pre_divide: assert property (@(posedge hclk) disable iff (!hresetn)
        (loop_ref_tick && $past(pre_q) == 3'h4) |-> !$past(loop_ref_tick)
            && !$past(loop_ref_tick, 2) && !$past(loop_ref_tick, 3) && !$past(loop_ref_tick, 4))
        else $error("prescaler divide by 5 ticked too early");

    a_post_direct: assert property (@(posedge hclk) disable iff (!hresetn)
        (valid_d && !loop_d && post_q == 2'h1) |=> core_khz == ($past(in_khz) >> 1))
        else $error("direct postscaler rate wrong");

    a_post_loop: assert property (@(posedge hclk) disable iff (!hresetn)
        (loop_d && post_q == 2'h3) |=> core_khz == CORE_16 && core_from_loop)
        else $error("loop postscaler did not give 16 MHz");

    a_low_xt_pre: assert property (@(posedge hclk) disable iff (!hresetn)
        (mode_low_xt(mode_q) && pre_q != 3'h0) |=> !valid_q && !loop_enable)
        else $error("low-speed crystal accepted with a prescaler");

    a_low_speed_usb: assert property (@(posedge hclk) disable iff (!hresetn)
        usb_low_speed |-> core_khz == CORE_24 && usb_khz == USB_LS_KHZ && core_from_loop)
        else $error("low-speed USB outside the 24 MHz loop plan");

    a_full_speed_usb: assert property (@(posedge hclk) disable iff (!hresetn)
        (valid_q && core_khz != CORE_24) |-> usb_khz == USB_FS_KHZ && !usb_low_speed)
        else $error("non-24 MHz plan not on full-speed USB");

    a_usb_clock_divider_sel_gate: assert property (@(posedge hclk) disable iff (!hresetn)
        usb_clock_divider_sel_q |=> !valid_q && core_khz == 17'h00000 && usb_khz == 17'h00000)
        else $error("plan applied with USB divider selected");

    a_loop_fixed: assert property (@(posedge hclk) disable iff (!hresetn)
        loop_enable |-> loop_khz == LOOP_KHZ && $past(pre_q) <= PRE_MAX)
        else $error("loop not at its fixed rate from a legal reference");

endmodule

// *** loop_tick_source.sv ***
// Model of the phase-locked loop output, seen as hclk-synchronous edge pulses.
// Assumes loop_enable from the block gates the loop; pulses stop while it is low.
`timescale 1ns/10ps
module loop_tick_source #(
    parameter int GAP = 3
) (
    input  wire logic hclk,
    input  wire logic hresetn,
    input  wire logic loop_enable,
    output logic      loop_out_tick
);
    int   cnt_q;
    int   cnt_d;
    logic tick_d;

    // Fixed output rate from a fixed reference; a halted loop makes no edges
    always_comb begin
        cnt_d  = 0;
        tick_d = 1'b0;
        if (loop_enable) begin
            cnt_d  = (cnt_q == GAP - 1) ? 0 : cnt_q + 1;
            tick_d = (cnt_q == GAP - 1);
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cnt_q         <= 0;
            loop_out_tick <= 1'b0;
        end else begin
            cnt_q         <= cnt_d;
            loop_out_tick <= tick_d;
        end
    end
endmodule

// *** test_usb_clock_divider_config.sv ***
// Self-checking bench for the clock divider configuration block.
// Assumes loop_tick_source pulses every 3 cycles and a task-based AHB-Lite master.
`timescale 1ns/10ps
module test_usb_clock_divider_config;
    import clkcfg_pkg::*;
    typedef struct {
        logic [31:0] cfg;
        khz_t        core;
        khz_t        usb;
        logic [4:0]  stat;
        logic [31:0] ref_n;
        logic [31:0] core_n;
    } row_t;

    logic        hclk, hresetn, hsel, hwrite;
    logic [31:0] haddr, hwdata, hrdata, rc, cc;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic        hreadyout, hresp, loop_out_tick, loop_enable, loop_ref_tick;
    logic        core_tick, core_from_loop, usb_low_speed;
    logic [4:0]  fast_osc_trim;
    khz_t        core_khz, usb_khz, loop_khz;
    int          n_fail, num_checks;
    row_t        rows [15];

    usb_clock_divider_config u_dut (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .loop_out_tick(loop_out_tick), .loop_enable(loop_enable),
        .loop_ref_tick(loop_ref_tick), .core_tick(core_tick),
        .core_from_loop(core_from_loop), .usb_low_speed(usb_low_speed),
        .fast_osc_trim(fast_osc_trim), .core_khz(core_khz), .usb_khz(usb_khz),
        .loop_khz(loop_khz)
    );

    loop_tick_source #(.GAP(3)) u_loop (
        .hclk(hclk), .hresetn(hresetn), .loop_enable(loop_enable),
        .loop_out_tick(loop_out_tick)
    );

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic tally_and_finish;
        if (n_fail == 0 && num_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // Ready and read data are sampled at the negedge so the rising edge never races
    task automatic wait_ready(output logic [31:0] d);
        logic r;
        int   n;
        n = 0;
        do begin
            @(negedge hclk);
            r = hreadyout;
            d = hrdata;
            @(posedge hclk);
            n++;
        end while (r !== 1'b1 && n < 50);
        if (r !== 1'b1) begin
            n_fail++;
        end
    endtask

    task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] wd,
                       output logic [31:0] rd);
        hsel   <= 1'b1;
        haddr  <= a;
        hwrite <= wr;
        htrans <= 2'h2;
        wait_ready(rd);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        wait_ready(rd);
    endtask

    task automatic wr32(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] unused;
        ahb(1'b1, {24'h0, a}, d, unused);
    endtask

    task automatic rd_chk(input logic [31:0] a, input logic [31:0] exp);
        logic [31:0] d;
        ahb(1'b0, a, 32'h0, d);
        check(d, exp);
    endtask

    task automatic trim_step(input logic [7:0] a, input logic [31:0] d, input logic [4:0] exp);
        wr32(a, d);
        repeat (2) @(posedge hclk);
        check({27'h0, fast_osc_trim}, {27'h0, exp});
    endtask

    initial begin
        hclk = 1'b0;
        forever #4 hclk = ~hclk;
    end

    initial begin
        repeat (30000) @(posedge hclk);
        n_fail++;
        tally_and_finish();
    end

    initial begin
        hresetn = 1'b0; hsel = 1'b0; haddr = 32'h0; htrans = 2'h0;
        hwrite = 1'b0; hsize = 3'h2; hwdata = 32'h0; n_fail = 0; num_checks = 0;
        rows = '{
            '{32'h0000, 17'h00FA0, 17'h0BB80, 5'h15, 360, 360},
            '{32'h0234, 17'h01388, 17'h0BB80, 5'h15, 72, 90},
            '{32'h0322, 17'h00FA0, 17'h0BB80, 5'h15, 120, 120},
            '{32'h0013, 17'h01F40, 17'h0BB80, 5'h15, 90, 180},
            '{32'h0331, 17'h007D0, 17'h0BB80, 5'h15, 180, 90},
            '{32'h0404, 17'h0BB80, 17'h0BB80, 5'h17, 72, 60},
            '{32'h0613, 17'h07D00, 17'h0BB80, 5'h17, 90, 40},
            '{32'h2722, 17'h05DC0, 17'h01770, 5'h1F, 120, 30},
            '{32'h0530, 17'h03E80, 17'h0BB80, 5'h17, 360, 20},
            '{32'h0120, 17'h00535, 17'h0BB80, 5'h15, 360, 120},
            '{32'h0101, 17'h00000, 17'h00000, 5'h10, 0, 0},
            '{32'h0005, 17'h00000, 17'h00000, 5'h00, 0, 0},
            '{32'h1000, 17'h00000, 17'h00000, 5'h10, 0, 0},
            '{32'h0800, 17'h00000, 17'h00000, 5'h10, 0, 0},
            '{32'h2402, 17'h0BB80, 17'h0BB80, 5'h17, 120, 60}
        };
        repeat (20) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        foreach (rows[i]) begin
            wr32(CFG_OFS, rows[i].cfg);
            repeat (40) @(posedge hclk);
            rc = 32'h0;
            cc = 32'h0;
            repeat (360) begin
                @(negedge hclk);
                rc += {31'h0, loop_ref_tick};
                cc += {31'h0, core_tick};
            end
            check(rc, rows[i].ref_n);
            check(cc, rows[i].core_n);
            check({15'h0, core_khz}, {15'h0, rows[i].core});
            check({15'h0, usb_khz}, {15'h0, rows[i].usb});
            check({15'h0, loop_khz}, rows[i].stat[0] ? 32'h17700 : 32'h0);
            check({29'h0, loop_enable, core_from_loop, usb_low_speed},
                  {29'h0, rows[i].stat[0], rows[i].stat[1], rows[i].stat[3]});
            @(posedge hclk);
            rd_chk({24'h0, STAT_OFS}, {27'h0, rows[i].stat});
            rd_chk({24'h0, CORE_OFS}, {15'h0, rows[i].core});
            rd_chk({24'h0, USB_OFS}, {15'h0, rows[i].usb});
        end
        wr32(CFG_OFS, 32'h0000);
        trim_step(TRIM_OFS, 32'h0F, 5'h0F);
        trim_step(STEP_OFS, 32'h01, 5'h0F);
        trim_step(TRIM_OFS, 32'h10, 5'h10);
        trim_step(STEP_OFS, 32'h02, 5'h10);
        trim_step(TRIM_OFS, 32'h00, 5'h00);
        trim_step(STEP_OFS, 32'h02, 5'h1F);
        trim_step(STEP_OFS, 32'h01, 5'h00);
        trim_step(STEP_OFS, 32'h01, 5'h01);
        trim_step(STEP_OFS, 32'h03, 5'h01);
        rd_chk({24'h0, TRIM_OFS}, 32'h01);
        rd_chk({24'h0, STEP_OFS}, 32'h0);
        check({15'h0, core_khz}, 32'h00FA0);
        check({15'h0, usb_khz}, 32'h0BB80);
        // Unmapped places answer zero and swallow writes
        wr32(8'h18, 32'h0234);
        ahb(1'b1, 32'h0000_0100, 32'h0234, rc);
        rd_chk(32'h18, 32'h0);
        rd_chk({24'h0, CFG_OFS}, 32'h0);
        wr32(CFG_OFS, 32'h0234);
        repeat (3) @(posedge hclk);
        hresetn <= 1'b0;
        @(negedge hclk);
        check({15'h0, core_khz}, 32'h0);
        check({29'h0, hresp, hreadyout, loop_enable}, 32'h2);
        check({27'h0, fast_osc_trim}, 32'h0);
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        repeat (3) @(posedge hclk);
        check({15'h0, core_khz}, 32'h00FA0);
        rd_chk({24'h0, CFG_OFS}, 32'h0);
        tally_and_finish();
    end
endmodule
